// ===== rtl/sfbfe_flash_end.sv
// Purpose: flash end of the serial link; framing, lane widths, modes, pause
// Assumes: user inputs are quasi-static; memory array lives elsewhere
// Notes: link logic runs on the serial clock; opcodes reported to clk domain
//
// Overview of operation
// - Select high floats every data output lane
// - No instruction before first select falling edge
// - Single lane input sampled on rising clock
// - Read data shifted out on falling clock
// - Clock modes zero and three both work
// - Dual reads use lanes zero and one
// - Quad reads use four lanes, need enable
// - Enable bit turns protect, pause into lanes
// - Four-lane mode entered by opcode, needs enable
// - Opcode takes two clocks four-lane, else eight
// - One mode at a time; exit opcode
// - Reset and software reset give single mode
// - Pause floats output, ignores input and clock
// - Pause only in single and dual operation
// - Pause begins only at a falling clock edge
// - Pause ends only at a falling clock edge
// - Pause keeps partial instruction state intact
// - Host keeps select low through pause
// - Protect pin with protect bit blocks writes
// - Protect bit and low pin refuse writes
`timescale 1ns/1ns
`include "sfbfe_defs.svh"
module sfbfe_flash_end #(
    parameter int DUMMY_CLKS = `SFBFE_DUMMY_CLKS
) (
    // Link
    sfbfe_link_if.flash link,
    // System
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic quad_enable_bit,
    input wire logic status_protect_bit,
    input wire logic [7:0] rd_data,
    // Report
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic status_write_ok,
    output logic four_lane_instruction_mode
);
    import sfbfe_pkg::*;

    // System domain
    logic cs_s1_ff, cs_s2_ff, armed_ff, link_rst_ff;
    logic tg_s1_ff, tg_s2_ff, tg_s3_ff, q4_s1_ff;
    // Link domain, persistent
    logic qe_s1_ff, qe_s2_ff, srp_s1_ff, srp_s2_ff;
    logic [7:0] rd_s1_ff, rd_s2_ff;
    logic qpi_ff, wel_ff, evt_tgl_ff, swok_ff;
    logic [7:0] op_ff;
    // Link domain, per frame
    sfbfe_phase_t phase_ff;
    logic [5:0] cnt_ff;
    logic [7:0] sh_ff, cur_op_ff, tx_ff;
    logic [2:0] txbit_ff;
    logic hold_ff;
    logic [3:0] out_ff, oe_ff;
    // Decode
    logic frame_rst, wp_n, hold_n, opc_done, status_ok_now, fast_ok, hold_ok, nxt_hold;
    logic [5:0] cnt_inc, opc_len;
    logic [7:0] nxt_sh, stat_byte, src_byte, cur_byte;
    sfbfe_width_t dw;

    // Arm only once select has been seen high after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_s1_ff <= 1'b0;
            cs_s2_ff <= 1'b0;
        end else begin
            cs_s1_ff <= link.cs_n;
            cs_s2_ff <= cs_s1_ff;
        end
    end

    // Until armed, the whole link side is held in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            armed_ff <= 1'b0;
            link_rst_ff <= 1'b1;
        end else begin
            if (cs_s2_ff) armed_ff <= 1'b1;
            link_rst_ff <= ~armed_ff;
        end
    end

    // Select high ends the frame even with the serial clock stopped
    assign frame_rst = link.cs_n | link_rst_ff;
    assign wp_n = link.lane[2];
    assign hold_n = link.lane[3];
    assign cnt_inc = cnt_ff + 6'h01;
    assign opc_len = qpi_ff ? `SFBFE_OPC_CLKS_4L : `SFBFE_OPC_CLKS_1L;
    assign nxt_sh = sfbfe_shift_in(sh_ff, link.lane, qpi_ff ? 3'h4 : 3'h1, link.lane[0]);
    assign opc_done = phase_ff == ph_opc && cnt_inc == opc_len;
    // Protect pin counts only while it is not a data lane
    assign status_ok_now = wel_ff & ~(srp_s2_ff & ~wp_n & ~qe_s2_ff);
    assign fast_ok = sfbfe_is_fast(nxt_sh) & (~sfbfe_is_quad(nxt_sh) | qe_s2_ff);

    // User levels into the link domain; stale for the first two clocks of a frame
    always_ff @(posedge link.sck or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            qe_s1_ff <= 1'b0;
            qe_s2_ff <= 1'b0;
            srp_s1_ff <= 1'b0;
            srp_s2_ff <= 1'b0;
            rd_s1_ff <= 8'h00;
            rd_s2_ff <= 8'h00;
        end else begin
            qe_s1_ff <= quad_enable_bit;
            qe_s2_ff <= qe_s1_ff;
            srp_s1_ff <= status_protect_bit;
            srp_s2_ff <= srp_s1_ff;
            rd_s1_ff <= rd_data;
            rd_s2_ff <= rd_s1_ff;
        end
    end

    // Mode and write latch; survive select, cleared by the link reset
    always_ff @(posedge link.sck or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            qpi_ff <= 1'b0;
            wel_ff <= 1'b0;
            evt_tgl_ff <= 1'b0;
            op_ff <= 8'h00;
            swok_ff <= 1'b0;
        end else if (opc_done && !hold_ff) begin
            op_ff <= nxt_sh;
            swok_ff <= status_ok_now;
            evt_tgl_ff <= ~evt_tgl_ff;
            case (nxt_sh)
                `SFBFE_OP_ENTER_4L: if (qe_s2_ff) qpi_ff <= 1'b1;
                `SFBFE_OP_EXIT_4L: qpi_ff <= 1'b0;
                `SFBFE_OP_RESET: begin
                    qpi_ff <= 1'b0;
                    wel_ff <= 1'b0;
                end
                `SFBFE_OP_WR_EN: wel_ff <= 1'b1;
                `SFBFE_OP_WR_DIS: wel_ff <= 1'b0;
                `SFBFE_OP_WR_STAT: wel_ff <= 1'b0;
                default: ;
            endcase
        end
    end

    // Frame sequencer on rising edges; frozen while paused
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            phase_ff <= ph_opc; // Fresh at select whatever the clock level
            cnt_ff <= 6'h00;
            sh_ff <= 8'h00;
            cur_op_ff <= 8'h00;
        end else if (!hold_ff) begin
            case (phase_ff)
                ph_opc: begin
                    sh_ff <= nxt_sh;
                    cnt_ff <= opc_done ? 6'h00 : cnt_inc;
                    if (opc_done) begin
                        cur_op_ff <= nxt_sh;
                        if (fast_ok) phase_ff <= ph_addr;
                        else if (nxt_sh == `SFBFE_OP_RD_STAT) phase_ff <= ph_data;
                        else phase_ff <= ph_ignore;
                    end
                end
                ph_addr: begin
                    cnt_ff <= cnt_inc;
                    if (cnt_inc == sfbfe_addr_clks(sfbfe_addr_w(cur_op_ff, qpi_ff))) begin
                        cnt_ff <= 6'h00;
                        phase_ff <= ph_dummy;
                    end
                end
                ph_dummy: begin
                    cnt_ff <= cnt_inc;
                    if (cnt_inc == 6'(DUMMY_CLKS)) phase_ff <= ph_data;
                end
                default: ;
            endcase
        end
    end

    // Status byte and read source
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`SFBFE_STAT_WEL] = wel_ff;
        stat_byte[`SFBFE_STAT_SRP] = srp_s2_ff;
    end
    assign src_byte = cur_op_ff == `SFBFE_OP_RD_STAT ? stat_byte : rd_s2_ff;
    assign cur_byte = txbit_ff == 3'h0 ? src_byte : tx_ff;
    assign dw = sfbfe_data_w(cur_op_ff, qpi_ff);
    // Pause pin exists only in single and dual operation
    assign hold_ok = ~qe_s2_ff & ~qpi_ff & ~sfbfe_is_quad(cur_op_ff);
    assign nxt_hold = hold_ok & ~hold_n;

    // Output shifter on falling edges; pause seen only at a falling edge
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            hold_ff <= 1'b0;
            out_ff <= 4'h0;
            oe_ff <= 4'h0;
            tx_ff <= 8'h00;
            txbit_ff <= 3'h0;
        end else begin
            hold_ff <= nxt_hold;
            if (phase_ff == ph_data && !nxt_hold) begin
                tx_ff <= 8'(cur_byte << dw);
                txbit_ff <= 3'(txbit_ff + dw);
                case (dw)
                    3'h4: begin
                        out_ff <= cur_byte[7:4];
                        oe_ff <= 4'hf;
                    end
                    3'h2: begin
                        out_ff <= {2'b00, cur_byte[7:6]};
                        oe_ff <= 4'h3;
                    end
                    default: begin
                        out_ff <= {2'b00, cur_byte[7], 1'b0};
                        oe_ff <= 4'h2;
                    end
                endcase
            end else begin
                oe_ff <= 4'h0;
            end
        end
    end

    assign link.lane_d = out_ff;
    assign link.lane_d_oe = oe_ff;

    // Opcode report back in clk; opcode word is stable once the toggle lands
    always_ff @(posedge clk) begin
        if (rst) begin
            tg_s1_ff <= 1'b0;
            tg_s2_ff <= 1'b0;
            tg_s3_ff <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h00;
            status_write_ok <= 1'b0;
        end else begin
            tg_s1_ff <= evt_tgl_ff;
            tg_s2_ff <= tg_s1_ff;
            tg_s3_ff <= tg_s2_ff;
            cmd_valid <= tg_s2_ff ^ tg_s3_ff;
            if (tg_s2_ff ^ tg_s3_ff) begin
                cmd_opcode <= op_ff;
                status_write_ok <= swok_ff;
            end
        end
    end

    // Current mode, one of two at any time
    always_ff @(posedge clk) begin
        if (rst) begin
            q4_s1_ff <= 1'b0;
            four_lane_instruction_mode <= 1'b0;
        end else begin
            q4_s1_ff <= qpi_ff;
            four_lane_instruction_mode <= q4_s1_ff;
        end
    end
endmodule : sfbfe_flash_end

// ===== rtl/sfbfe_defs.svh
// Purpose: shared constants of the serial flash bus front end
// Assumes: included by bare name; guarded against double inclusion
// Notes: opcodes, field positions and timing counts only
`ifndef SFBFE_DEFS_SVH
`define SFBFE_DEFS_SVH
`define SFBFE_OP_DUAL_OUT 8'h3b
`define SFBFE_OP_DUAL_IO 8'hbb
`define SFBFE_OP_QUAD_OUT 8'h6b
`define SFBFE_OP_QUAD_IO 8'heb
`define SFBFE_OP_ENTER_4L 8'h38
`define SFBFE_OP_EXIT_4L 8'hff
`define SFBFE_OP_RESET 8'h99
`define SFBFE_OP_WR_EN 8'h06
`define SFBFE_OP_WR_DIS 8'h04
`define SFBFE_OP_WR_STAT 8'h01
`define SFBFE_OP_RD_STAT 8'h05
// Opcode length in clocks, one lane and four lanes
`define SFBFE_OPC_CLKS_1L 6'h08
`define SFBFE_OPC_CLKS_4L 6'h02
`define SFBFE_ADDR_BITS 24
`define SFBFE_DUMMY_CLKS 8
// Status byte field positions
`define SFBFE_STAT_WEL 1
`define SFBFE_STAT_SRP 7
// Timing
`define SFBFE_CLK_PERIOD_NS 4
`define SFBFE_SCK_PERIOD_NS 80
`define SFBFE_SCK_HALF_CYC (`SFBFE_SCK_PERIOD_NS / (2 * `SFBFE_CLK_PERIOD_NS))
`endif

// ===== rtl/sfbfe_pkg.sv
// Purpose: types and shared decoders of the serial flash bus front end
// Assumes: sfbfe_defs.svh carries the opcodes
// Notes: both ends decode lane widths with the same functions
package sfbfe_pkg;
`include "sfbfe_defs.svh"

    typedef enum {ph_opc, ph_addr, ph_dummy, ph_data, ph_ignore} sfbfe_phase_t;
    typedef enum {hs_idle, hs_lead, hs_run, hs_trail, hs_gap} sfbfe_hstate_t;
    typedef logic [2:0] sfbfe_width_t;

    function automatic logic sfbfe_is_quad(input logic [7:0] op);
        return op == `SFBFE_OP_QUAD_OUT || op == `SFBFE_OP_QUAD_IO;
    endfunction : sfbfe_is_quad

    function automatic logic sfbfe_is_fast(input logic [7:0] op);
        return sfbfe_is_quad(op) || op == `SFBFE_OP_DUAL_OUT || op == `SFBFE_OP_DUAL_IO;
    endfunction : sfbfe_is_fast

    function automatic sfbfe_width_t sfbfe_addr_w(input logic [7:0] op, input logic four_l);
        if (four_l || op == `SFBFE_OP_QUAD_IO) return 3'h4;
        if (op == `SFBFE_OP_DUAL_IO) return 3'h2;
        return 3'h1;
    endfunction : sfbfe_addr_w

    function automatic sfbfe_width_t sfbfe_data_w(input logic [7:0] op, input logic four_l);
        if (four_l || sfbfe_is_quad(op)) return 3'h4;
        if (op == `SFBFE_OP_DUAL_OUT || op == `SFBFE_OP_DUAL_IO) return 3'h2;
        return 3'h1;
    endfunction : sfbfe_data_w

    function automatic logic [5:0] sfbfe_addr_clks(input sfbfe_width_t w);
        return 6'(`SFBFE_ADDR_BITS / int'(w));
    endfunction : sfbfe_addr_clks

    // Shift lanes in MSB first; ser is the lane used when one bit wide
    function automatic logic [7:0] sfbfe_shift_in(input logic [7:0] sh, input logic [3:0] lanes,
                                                  input sfbfe_width_t w, input logic ser);
        if (w == 3'h4) return {sh[3:0], lanes};
        if (w == 3'h2) return {sh[5:0], lanes[1:0]};
        return {sh[6:0], ser};
    endfunction : sfbfe_shift_in
endpackage : sfbfe_pkg

// ===== rtl/sfbfe_link_if.sv
// Purpose: the four-lane serial flash link between host and flash ends
// Assumes: each end drives a lane only with its enable high
// Notes: undriven lanes read high, as with a pull-up; the flash end wins a clash
`timescale 1ns/1ns
interface sfbfe_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] lane_h;
    logic [3:0] lane_h_oe;
    logic [3:0] lane_d;
    logic [3:0] lane_d_oe;
    logic [3:0] lane;

    // Resolved wire level
    assign lane = (lane_d_oe & lane_d) | (~lane_d_oe & lane_h_oe & lane_h) | (~lane_d_oe & ~lane_h_oe);

    modport flash (input cs_n, input sck, input lane, output lane_d, output lane_d_oe);
    modport host (output cs_n, output sck, output lane_h, output lane_h_oe, input lane);
endinterface : sfbfe_link_if

// ===== rtl/sfbfe_host_end.sv
// Purpose: host end; frames one instruction per start and reads data back
// Assumes: user keeps the opcode legal for the mode it believes in
// Notes: serial clock made by a divider of clk; lane inputs pass two flops
`timescale 1ns/1ns
`include "sfbfe_defs.svh"
module sfbfe_host_end #(
    parameter int HALF_DIV = `SFBFE_SCK_HALF_CYC,
    parameter int DUMMY_CLKS = `SFBFE_DUMMY_CLKS
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [23:0] addr,
    input wire logic [7:0] rd_bytes,
    input wire logic four_lane_instruction_mode,
    input wire logic clock_mode3,
    input wire logic pause_req,
    input wire logic write_protect_n,
    // Answer
    output logic busy,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    // Link
    sfbfe_link_if.host link
);
    import sfbfe_pkg::*;

    sfbfe_hstate_t st_ff;
    sfbfe_phase_t phase_ff;
    logic [7:0] div_ff, op_ff, len_ff, nbyte_ff, rx_ff, nxt_rx;
    logic [5:0] cnt_ff, cnt_inc;
    logic [31:0] tx_ff;
    logic [2:0] rxbit_ff, nxt_rxbit;
    sfbfe_width_t w_sh_ff, w_cur, dw;
    logic sck_ff, cs_n_ff, fourl_ff, mode3_ff, paused_ff, tick, quad_use;
    logic [3:0] lh_ff, lhoe_ff, nxt_lh, nxt_lhoe, lane_s1_ff, lane_s2_ff;

    assign tick = div_ff == 8'(HALF_DIV - 1);
    assign cnt_inc = cnt_ff + 6'h01;
    assign dw = sfbfe_data_w(op_ff, fourl_ff);
    assign w_cur = phase_ff == ph_opc ? (fourl_ff ? 3'h4 : 3'h1) :
                   phase_ff == ph_addr ? sfbfe_addr_w(op_ff, fourl_ff) : dw;
    assign quad_use = fourl_ff | sfbfe_is_quad(op_ff);
    assign nxt_rx = sfbfe_shift_in(rx_ff, lane_s2_ff, dw, lane_s2_ff[1]);
    assign nxt_rxbit = 3'(rxbit_ff + dw);

    // Lane inputs come from the far end
    always_ff @(posedge clk) begin
        lane_s1_ff <= rst ? 4'h0 : link.lane;
        lane_s2_ff <= rst ? 4'h0 : lane_s1_ff;
    end

    // Half-period divider, idle outside a frame
    always_ff @(posedge clk) begin
        if (rst || st_ff == hs_idle || tick) div_ff <= 8'h00;
        else div_ff <= div_ff + 8'h01;
    end

    // Lane drive; pins 2 and 3 stay protect and pause unless quad is in use
    always_comb begin
        nxt_lh = {~paused_ff, write_protect_n, 2'b00};
        nxt_lhoe = quad_use ? 4'h0 : 4'hc;
        if (phase_ff == ph_opc || phase_ff == ph_addr) begin
            case (w_cur)
                3'h4: begin nxt_lh = tx_ff[31:28]; nxt_lhoe = 4'hf; end
                3'h2: begin nxt_lh[1:0] = tx_ff[31:30]; nxt_lhoe[1:0] = 2'b11; end
                default: begin nxt_lh[0] = tx_ff[31]; nxt_lhoe[0] = 1'b1; end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        lh_ff <= rst ? 4'hc : nxt_lh;
        lhoe_ff <= rst ? 4'h0 : nxt_lhoe;
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= hs_idle; phase_ff <= ph_ignore; cs_n_ff <= 1'b1; sck_ff <= 1'b0; busy <= 1'b0;
            rd_valid <= 1'b0; rd_byte <= 8'h00; op_ff <= 8'h00; len_ff <= 8'h00; nbyte_ff <= 8'h00;
            rx_ff <= 8'h00; rxbit_ff <= 3'h0; cnt_ff <= 6'h00; tx_ff <= 32'h0; w_sh_ff <= 3'h1;
            fourl_ff <= 1'b0; mode3_ff <= 1'b0; paused_ff <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (st_ff)
                hs_idle: begin
                    sck_ff <= clock_mode3;
                    if (start) begin
                        op_ff <= opcode; len_ff <= rd_bytes; tx_ff <= {opcode, addr};
                        fourl_ff <= four_lane_instruction_mode; mode3_ff <= clock_mode3;
                        phase_ff <= ph_opc; cnt_ff <= 6'h00; rxbit_ff <= 3'h0; nbyte_ff <= 8'h00;
                        cs_n_ff <= 1'b0; busy <= 1'b1; st_ff <= hs_lead;
                    end
                end
                hs_lead: if (tick) begin
                    sck_ff <= 1'b0;
                    st_ff <= hs_run;
                end
                hs_run: if (tick) begin
                    if (sck_ff) begin
                        sck_ff <= 1'b0;
                        tx_ff <= tx_ff << w_sh_ff;
                    end else if (paused_ff || (pause_req && !quad_use)) begin
                        paused_ff <= pause_req; // Clock frozen low, select kept low
                    end else begin
                        sck_ff <= 1'b1;
                        w_sh_ff <= w_cur;
                        cnt_ff <= cnt_inc;
                        case (phase_ff)
                            ph_opc: if (cnt_inc == (fourl_ff ? `SFBFE_OPC_CLKS_4L : `SFBFE_OPC_CLKS_1L)) begin
                                cnt_ff <= 6'h00;
                                if (sfbfe_is_fast(op_ff)) phase_ff <= ph_addr;
                                else if (op_ff == `SFBFE_OP_RD_STAT && len_ff != 8'h00) phase_ff <= ph_data;
                                else begin phase_ff <= ph_ignore; st_ff <= hs_trail; end
                            end
                            ph_addr: if (cnt_inc == sfbfe_addr_clks(w_cur)) begin
                                cnt_ff <= 6'h00;
                                phase_ff <= ph_dummy;
                            end
                            ph_dummy: if (cnt_inc == 6'(DUMMY_CLKS)) begin
                                if (len_ff != 8'h00) phase_ff <= ph_data;
                                else begin phase_ff <= ph_ignore; st_ff <= hs_trail; end
                            end
                            default: begin
                                rx_ff <= nxt_rx;
                                rxbit_ff <= nxt_rxbit;
                                if (nxt_rxbit == 3'h0) begin
                                    rd_valid <= 1'b1;
                                    rd_byte <= nxt_rx;
                                    nbyte_ff <= nbyte_ff + 8'h01;
                                    if (nbyte_ff + 8'h01 == len_ff) begin phase_ff <= ph_ignore; st_ff <= hs_trail; end
                                end
                            end
                        endcase
                    end
                end
                hs_trail: if (tick) begin
                    if (!mode3_ff && sck_ff) sck_ff <= 1'b0; // Mode 0 ends with clock low
                    else begin cs_n_ff <= 1'b1; st_ff <= hs_gap; end
                end
                default: if (tick) begin
                    busy <= 1'b0;
                    st_ff <= hs_idle;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sck = sck_ff;
    assign link.lane_h = lh_ff;
    assign link.lane_h_oe = lhoe_ff;
endmodule : sfbfe_host_end

// ===== test/sfbfe_link_assertions.sv
// Purpose: link timing checks between the host and flash ends
// Assumes: sampled on host clk; HALF_DIV equals the host divider
// Notes: flash lane moves show in the same clk sample as the serial edge
`timescale 1ns/1ns
module sfbfe_link_assertions #(
    parameter int HALF_DIV = 2
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] lane_h,
    input wire logic [3:0] lane_h_oe,
    input wire logic [3:0] lane_d,
    input wire logic [3:0] lane_d_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic sck_q_ff, sel_rise_ff;
    logic [7:0] hcnt_ff;
    // Cycles since sck moved; saturates so long idles never wrap
    always_ff @(posedge clk) begin
        sck_q_ff <= rst ? 1'b0 : sck;
        hcnt_ff <= (rst || sck != sck_q_ff) ? 8'h00 : hcnt_ff + {7'h00, hcnt_ff != 8'hff};
    end
    // Rise seen in this frame; the mode 3 lead fall ends an idle high, not a clock
    always_ff @(posedge clk) begin
        sel_rise_ff <= !rst && !cs_n && (sel_rise_ff || (sck && !sck_q_ff));
    end
    // Framing, edge use and lane ownership
    property p_idle; cs_n && $past(cs_n) |-> lane_d_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("lane driven while deselected");
    property p_drop; $rose(cs_n) |-> ##[0:1] lane_d_oe == 4'h0; endproperty
    a_drop: assert property (p_drop) else $error("lane kept after deselect");
    property p_turn_on; $rose(|lane_d_oe) |-> !sck && !cs_n; endproperty
    a_turn_on: assert property (p_turn_on) else $error("drive began off a low clock");
    property p_shift; !cs_n && $changed(lane_d) |-> !sck; endproperty
    a_shift: assert property (p_shift) else $error("output moved while clock high");
    property p_host_hold; !cs_n && $rose(sck) |-> $stable(lane_h) && $stable(lane_h_oe); endproperty
    a_host_hold: assert property (p_host_hold) else $error("input moved while clock high");
    property p_no_clash; (lane_d_oe & lane_h_oe) == 4'h0; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive a lane");
    property p_sel_edge; $fell(cs_n) |-> $stable(sck) ##1 $stable(sck); endproperty
    a_sel_edge: assert property (p_sel_edge) else $error("clock moved at select");
    property p_high; $fell(sck) && !cs_n && sel_rise_ff && hcnt_ff < 8'(2 * HALF_DIV) |->
        hcnt_ff == 8'(HALF_DIV - 1); endproperty
    a_high: assert property (p_high) else $error("clock high phase wrong");
    // Main scenarios
    c_mode3: cover property ($fell(cs_n) && sck);
    c_quad: cover property (lane_d_oe == 4'hf);
    c_pause: cover property (!cs_n && lane_h_oe[3] && !lane_h[3] && !sck && hcnt_ff > 8'h08);
endmodule : sfbfe_link_assertions

// ===== test/tb_top.sv
// Purpose: self-checking bench for host and flash ends joined by the link
// Assumes: short divider and dummy count; state carries from row to row
// Notes: inputs change on falling clk, outputs are sampled there settled
`timescale 1ns/1ns
module tb_top;
    import sfbfe_pkg::*;
    // Row: opcode, expected byte, byte count, flags qe,sp,mode3,wp_n,four-lane after,write ok
    typedef struct packed {logic [7:0] op; logic [7:0] eb; logic [1:0] nb; logic [5:0] f;} sfbfe_row_t;
    logic clk, rst, start, pause_req, busy, rd_valid, qe, sp, m3, wp_n, h4l, cmd_valid, ok, f4l;
    logic [7:0] opcode, nbytes, rd_byte, cmd_opcode, seen_op, seen_byte, rdd;
    int num_errors = 0;
    int num_checks = 0;
    int seen_n;
    sfbfe_row_t rows [19] = '{24'h05004c, 24'h060010, 24'h010010, 24'h060014, 24'h010015, 24'h060014,
        24'h058254, 24'h3ba594, 24'hbba55c, 24'h6ba574, 24'heba57c, 24'h380036, 24'h058276, 24'hff0034,
        24'h380036, 24'h990034, 24'h058074, 24'h6bff54, 24'h380014};
    sfbfe_link_if link ();
    // Host samples through two flops, so the half period must exceed two clk
    sfbfe_host_end #(.HALF_DIV(4), .DUMMY_CLKS(4)) i_sfbfe_host_end (.clk(clk), .rst(rst), .start(start),
        .opcode(opcode), .addr(24'h5a5a5a), .rd_bytes(nbytes), .four_lane_instruction_mode(h4l), .clock_mode3(m3),
        .pause_req(pause_req), .write_protect_n(wp_n), .busy(busy), .rd_valid(rd_valid), .rd_byte(rd_byte),
        .link(link));
    sfbfe_flash_end #(.DUMMY_CLKS(4)) i_sfbfe_flash_end (.link(link), .clk(clk), .rst(rst),
        .quad_enable_bit(qe), .status_protect_bit(sp), .rd_data(rdd), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .status_write_ok(ok), .four_lane_instruction_mode(f4l));
    sfbfe_link_assertions #(.HALF_DIV(4)) i_sfbfe_link_assertions (.clk(clk), .rst(rst), .cs_n(link.cs_n),
        .sck(link.sck), .lane_h(link.lane_h), .lane_h_oe(link.lane_h_oe), .lane_d(link.lane_d),
        .lane_d_oe(link.lane_d_oe));
    // Clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Reported opcode and read bytes, taken once settled
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) seen_op = cmd_opcode;
        if (rd_valid === 1'b1) seen_byte = rd_byte;
        if (rd_valid === 1'b1) seen_n++;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic launch(input logic [7:0] op, input logic [7:0] nb);
        {start, opcode, nbytes, seen_op} = {1'b1, op, nb, 8'h00};
        seen_n = 0;
        @(negedge clk);
        start = 1'b0;
    endtask : launch
    // Bounded wait for the frame end, then room for the opcode report
    task automatic wait_idle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask : wait_idle
    task automatic run_row(input sfbfe_row_t r);
        {qe, sp, m3, wp_n} = r.f[5:2];
        repeat (4) @(negedge clk);
        launch(r.op, {6'h00, r.nb});
        wait_idle();
        chk("opcode", seen_op, r.op);
        chk("mode", {7'h00, f4l}, {7'h00, r.f[1]});
        chk("count", 8'(seen_n), {6'h00, r.nb});
        if (r.nb != 2'h0) chk("data", seen_byte, r.eb);
        if (r.op == 8'h01) chk("write_ok", {7'h00, ok}, {7'h00, r.f[0]});
        h4l = r.f[1];
    endtask : run_row
    task automatic tally_and_finish;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        {rst, start, pause_req, qe, sp, m3, wp_n, h4l, opcode, nbytes} = {1'b1, 23'h000000};
        rdd = 8'ha5;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        foreach (rows[i]) run_row(rows[i]);
        // Pause in mid address: clock stands low, the read then ends intact
        {qe, sp, m3, wp_n} = 4'h5;
        rdd = 8'h3c;
        repeat (4) @(negedge clk);
        launch(8'h3b, 8'h02);
        repeat (120) @(negedge clk);
        pause_req = 1'b1;
        repeat (12) @(negedge clk);
        for (int k = 0; k < 16; k++) begin
            chk("paused_clock", {7'h00, link.sck}, 8'h00);
            @(negedge clk);
        end
        pause_req = 1'b0;
        wait_idle();
        chk("pause_data", seen_byte, 8'h3c);
        chk("pause_count", 8'(seen_n), 8'h02);
        // Reset in mid frame out of four-lane mode; the next frame starts clean
        run_row(24'h380036);
        launch(8'h05, 8'h01);
        repeat (20) @(negedge clk);
        rst = 1'b1;
        repeat (10) @(negedge clk);
        chk("reset_busy", {7'h00, busy}, 8'h00);
        chk("reset_mode", {7'h00, f4l}, 8'h00);
        {rst, h4l} = 2'h0;
        repeat (10) @(negedge clk);
        run_row(24'h058074);
        tally_and_finish();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
